// file: wd_pkg.sv
// Purpose: Shared constants for the watchdog control unit
// Assumes: 8-bit control register reached through a dedicated SFR port
// Notes:   Counts are in crystal periods, delivered as a tick input
package wd_pkg;

  // Register width and field positions
  localparam int          CTRL_W        = 8;
  localparam int          BIT_UNLOCK    = 0;            // control_write_unlock
  localparam int          BIT_ENABLE    = 1;            // watchdog_enable_refresh
  localparam int          BIT_STATUS    = 2;            // timeout_status_flag
  localparam int          BIT_RESPONSE  = 3;            // expiry_response_select
  localparam int          PRE_LSB       = 4;            // Prescaler field low bit
  localparam int          PRE_W         = 4;            // Prescaler field width

  // Reset value of the control register
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Prescaler encodings
  localparam logic [3:0]  PRE_MAX_TIMED = 4'h7;         // Last timed setting
  localparam logic [3:0]  PRE_IMMEDIATE = 4'h8;         // Forces a reset at once

  // Timeout is 2^pre * 2^9 crystal periods
  localparam int          BASE_SHIFT    = 9;
  localparam int          CNT_W         = 17;           // Holds 2^7 * 2^9 - 1

  // Response select encoding
  localparam logic        RESP_RESET    = 1'b0;
  localparam logic        RESP_IRQ      = 1'b1;

endpackage

// file: wd_interval_counter.sv
// Purpose: Counts crystal ticks and flags the end of a watchdog period
// Assumes: tick is a one-cycle pulse per crystal period, synchronous to clock
// Notes:   Restart wins over counting; reserved prescaler values never expire
`timescale 1ns/1ps
module wd_interval_counter
#(
  parameter int CNT_WIDTH = wd_pkg::CNT_W
)
(
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire logic                       run,
  input  wire logic                       restart,
  input  wire logic                       tick,
  input  wire logic [wd_pkg::PRE_W-1:0]   prescale,
  output logic                            expire,
  output logic      [CNT_WIDTH-1:0]       count
);
  import wd_pkg::*;

  logic [CNT_WIDTH-1:0] cnt_r;     // Elapsed ticks
  logic [CNT_WIDTH-1:0] cnt_nxt;   // Next elapsed ticks
  logic [CNT_WIDTH-1:0] limit;     // Last tick index of the period
  logic                 expire_r;  // Registered expiry pulse
  logic                 timed;     // Prescaler holds a timed value
  logic                 immediate; // Prescaler asks for instant expiry
  logic                 hitLimit;  // Period complete on this tick
  logic                 fire;      // Expiry this cycle

  // Period length decode
  assign timed     = (prescale <= PRE_MAX_TIMED);
  assign immediate = (prescale == PRE_IMMEDIATE);
  // Shift amount kept 5 bits wide so the base shift of 9 is not cut
  assign limit     = CNT_WIDTH'((CNT_WIDTH'(1) << (5'(prescale[2:0]) + 5'(BASE_SHIFT))) - CNT_WIDTH'(1)); // RULE_08
  assign hitLimit  = tick && (cnt_r == limit);
  // Immediate expiry is held off while its own pulse is out, so one request is raised, not two
  assign fire      = run && !restart && ((timed && hitLimit) || (immediate && !expire_r)); // RULE_08

  // Counter advance; restart or stop clears so each refresh starts a full period
  assign cnt_nxt = (!run || restart || fire) ? '0 :
                   (tick && timed)           ? CNT_WIDTH'(cnt_r + CNT_WIDTH'(1)) :
                                               cnt_r;

  // Counter and pulse flops
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r    <= '0;
      expire_r <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt;
      expire_r <= fire;
    end
  end

  assign expire = expire_r;
  assign count  = cnt_r;

endmodule

// file: watchdog_control_unit.sv
// Purpose: Watchdog supervisor with a guarded 8-bit control register
// Assumes: SFR write and instruction-end strobes are synchronous one-cycle pulses
// Notes:   Outputs are flops; a write lands in the cycle its instruction ends
// Summary of operation
// RULE_01 - Interrupt response raises unmaskable high-priority interrupt
// RULE_02 - Timeout sets status flag at bit 2
// RULE_03 - Status clears by software zero or hardware reset
// RULE_04 - Setting enable bit arms and refreshes watchdog
// RULE_05 - Enable clears: write zero, reset, supply interrupt
// RULE_06 - Control write accepted only right after unlock
// RULE_07 - Software masks interrupts around the unlock sequence
// RULE_08 - Prescaler picks 2^pre*512 periods; 8 immediate
// RULE_09 - Bit 3 selects reset or interrupt response
// RULE_10 - Unlock lapses after any other instruction
`timescale 1ns/1ps
module watchdog_control_unit
#(
  parameter int CNT_WIDTH = wd_pkg::CNT_W
)
(
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire logic                       ctrlWrite,
  input  wire logic [wd_pkg::CTRL_W-1:0]  ctrlWrData,
  input  wire logic                       instrEnd,
  input  wire logic                       xtalTick,
  input  wire logic                       supplyMonitorIrq,
  output logic      [wd_pkg::CTRL_W-1:0]  watchdogControl,
  output logic                            wdIrq,
  output logic                            wdResetReq
);
  import wd_pkg::*;

  logic [CTRL_W-1:0]    ctrl_r;      // Control register
  logic [CTRL_W-1:0]    ctrl_nxt;    // Next control register
  logic                 irq_r;       // Interrupt pulse flop
  logic                 rst_r;       // Reset request pulse flop
  logic                 expire;      // Period elapsed while armed
  logic [CNT_WIDTH-1:0] count;       // Elapsed ticks, for checks
  logic                 unlocked;    // Write permission held
  logic                 accept;      // Full write taken this cycle
  logic                 unlockOnly;  // Locked write that only sets permission
  logic                 lapse;       // Another instruction ended first
  logic                 refresh;     // Accepted write with enable set
  logic                 respIrq;     // Interrupt response chosen
  logic                 immediate;   // Prescaler forces instant reset
  logic                 toIrq;       // Expiry answered by interrupt
  logic                 toReset;     // Expiry answered by reset
  logic                 statusNxt;   // Next status flag
  logic                 enableNxt;   // Next enable bit
  logic                 unlockNxt;   // Next unlock bit

  // Write guard decode
  assign unlocked   = ctrl_r[BIT_UNLOCK];
  assign accept     = ctrlWrite && unlocked;                          // RULE_06
  assign unlockOnly = ctrlWrite && !unlocked && ctrlWrData[BIT_UNLOCK]; // RULE_06
  assign lapse      = instrEnd && !ctrlWrite && unlocked;             // RULE_10
  assign refresh    = accept && ctrlWrData[BIT_ENABLE];               // RULE_04

  // Response decode
  assign respIrq   = (ctrl_r[BIT_RESPONSE] == RESP_IRQ);               // RULE_09
  assign immediate = (ctrl_r[PRE_LSB +: PRE_W] == PRE_IMMEDIATE);
  assign toIrq     = expire && respIrq && !immediate;                 // RULE_01
  assign toReset   = expire && (!respIrq || immediate);               // RULE_09

  // Status flag: expiry wins over a software clear in the same cycle
  assign statusNxt = expire ? 1'b1 :                                  // RULE_02
                     accept ? ctrlWrData[BIT_STATUS] :                // RULE_03
                              ctrl_r[BIT_STATUS];

  // Enable bit: supply interrupt and reset response always drop it
  assign enableNxt = (supplyMonitorIrq || toReset) ? 1'b0 :           // RULE_05
                     accept ? ctrlWrData[BIT_ENABLE] :                // RULE_04
                              ctrl_r[BIT_ENABLE];

  // Permission: one instruction wide, consumed by the write it allows
  assign unlockNxt = unlockOnly ? 1'b1 :
                     (accept || lapse) ? 1'b0 :                       // RULE_10
                                         unlocked;

  // Full register next value; fields above bit 2 change only by accepted writes
  assign ctrl_nxt = {accept ? ctrlWrData[CTRL_W-1:BIT_RESPONSE] : ctrl_r[CTRL_W-1:BIT_RESPONSE],
                     statusNxt, enableNxt, unlockNxt};

  // Period timer; runs only while enabled
  wd_interval_counter #(
    .CNT_WIDTH (CNT_WIDTH)
  ) u_counter (
    .clock    (clock),
    .rstn     (rstn),
    .run      (ctrl_r[BIT_ENABLE]),
    .restart  (refresh),
    .tick     (xtalTick),
    .prescale (ctrl_r[PRE_LSB +: PRE_W]),
    .expire   (expire),
    .count    (count)
  );

  // Register and response flops; the external reset clears them asynchronously
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= CTRL_RESET;  // RULE_03
      irq_r  <= 1'b0;
      rst_r  <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      irq_r  <= toIrq;       // RULE_01
      rst_r  <= toReset;     // RULE_09
    end
  end

  // Interrupt is a plain pulse; it has no mask input, so interrupt disable cannot hide it
  assign watchdogControl = ctrl_r;
  assign wdIrq           = irq_r;
  assign wdResetReq      = rst_r;

  // Checks
  property p_irq_on_expiry;
    @(posedge clock) disable iff (!rstn)
      (expire && respIrq && !immediate) |=> (wdIrq && !wdResetReq);
  endproperty
  a_irq_on_expiry: assert property (p_irq_on_expiry) else $error("interrupt missing after expiry"); // RULE_01

  property p_status_set;
    @(posedge clock) disable iff (!rstn)
      expire |=> watchdogControl[BIT_STATUS];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status flag not set on timeout"); // RULE_02

  property p_status_clear;
    @(posedge clock) disable iff (!rstn)
      (accept && !ctrlWrData[BIT_STATUS] && !expire) |=> !watchdogControl[BIT_STATUS];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status flag did not clear"); // RULE_03

  property p_refresh_restarts;
    @(posedge clock) disable iff (!rstn)
      (refresh && !supplyMonitorIrq && !toReset) |=> (count == '0);
  endproperty
  a_refresh_restarts: assert property (p_refresh_restarts) else $error("refresh did not restart period"); // RULE_04

  property p_supply_clears;
    @(posedge clock) disable iff (!rstn)
      supplyMonitorIrq |=> !watchdogControl[BIT_ENABLE];
  endproperty
  a_supply_clears: assert property (p_supply_clears) else $error("enable survived supply interrupt"); // RULE_05

  property p_locked_ignored;
    @(posedge clock) disable iff (!rstn)
      (ctrlWrite && !unlocked && !expire) |=> $stable(watchdogControl[CTRL_W-1:BIT_RESPONSE]);
  endproperty
  a_locked_ignored: assert property (p_locked_ignored) else $error("locked write changed register"); // RULE_06

  property p_immediate_reset;
    @(posedge clock) disable iff (!rstn)
      (immediate && ctrl_r[BIT_ENABLE] && !refresh && !supplyMonitorIrq) |-> ##[1:2] wdResetReq;
  endproperty
  a_immediate_reset: assert property (p_immediate_reset) else $error("immediate reset not issued"); // RULE_08

  property p_reset_response;
    @(posedge clock) disable iff (!rstn)
      (expire && !respIrq) |=> (wdResetReq && !wdIrq && !watchdogControl[BIT_ENABLE]);
  endproperty
  a_reset_response: assert property (p_reset_response) else $error("reset response wrong"); // RULE_09

  property p_unlock_lapses;
    @(posedge clock) disable iff (!rstn)
      lapse |=> !watchdogControl[BIT_UNLOCK];
  endproperty
  a_unlock_lapses: assert property (p_unlock_lapses) else $error("write permission did not lapse"); // RULE_10

  property p_cov_irq;
    @(posedge clock) disable iff (!rstn) wdIrq;
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_reset;
    @(posedge clock) disable iff (!rstn) wdResetReq;
  endproperty
  c_cov_reset: cover property (p_cov_reset);

  property p_cov_unlock_write;
    @(posedge clock) disable iff (!rstn) unlockOnly ##1 accept;
  endproperty
  c_cov_unlock_write: cover property (p_cov_unlock_write);

  property p_cov_lapse;
    @(posedge clock) disable iff (!rstn) lapse;
  endproperty
  c_cov_lapse: cover property (p_cov_lapse);

endmodule

// file: watchdog_control_unit_test.sv
// Purpose: Self-checking bench for the watchdog control unit
// Assumes: One crystal tick per clock, so prescaler 0 expires after 512 cycles
// Notes:   Each scenario is its own task; a cycle ceiling cuts hangs short
`timescale 1ns/1ps
module watchdog_control_unit_test;
  import wd_pkg::*;
  logic              clock = 1'b0;  // 40 MHz core clock
  logic              rstn = 1'b0;   // External hardware reset
  logic              ctrlWrite = 1'b0;
  logic [CTRL_W-1:0] ctrlWrData = 8'h00;
  logic              instrEnd = 1'b0;
  logic              xtalTick = 1'b1;  // Every cycle, to keep periods short
  logic              supplyMonitorIrq = 1'b0;
  logic [CTRL_W-1:0] watchdogControl;
  logic              wdIrq;
  logic              wdResetReq;
  int                errors = 0;    // Mismatch count
  int                checked = 0;   // Comparison count
  int                cycles = 0;    // Hang guard
  int                irqCount = 0;  // Interrupt pulses seen
  int                rstCount = 0;  // Reset requests seen
  int                n;

  watchdog_control_unit uut (.clock(clock), .rstn(rstn), .ctrlWrite(ctrlWrite), .ctrlWrData(ctrlWrData),
    .instrEnd(instrEnd), .xtalTick(xtalTick), .supplyMonitorIrq(supplyMonitorIrq),
    .watchdogControl(watchdogControl), .wdIrq(wdIrq), .wdResetReq(wdResetReq));

  // Clock
  always #12.5 clock = ~clock;

  // Pulse counters; pulses last one cycle, so each edge counts at most once
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (wdIrq === 1'b1) irqCount <= irqCount + 1;
    if (wdResetReq === 1'b1) rstCount <= rstCount + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic doReset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
  endtask

  // One write instruction; its instruction ends in the same cycle
  task automatic wrCtrl(input logic [7:0] d);
    @(posedge clock);
    ctrlWrite <= 1'b1;
    instrEnd <= 1'b1;
    ctrlWrData <= d;
    @(posedge clock);
    ctrlWrite <= 1'b0;
    instrEnd <= 1'b0;
    #1;
  endtask

  // Unlock then full write as the very next instruction
  task automatic unlockWrite(input logic [7:0] d);
    wrCtrl(8'h01);
    wrCtrl(d);
  endtask

  // Wait, bounded, for the next interrupt or reset pulse
  task automatic waitEvt(input bit useRst, input int lim, output int k);
    int start;
    start = useRst ? rstCount : irqCount;
    k = 0;
    while (((useRst ? rstCount : irqCount) == start) && k < lim)
    begin
      @(posedge clock);
      #1;
      k++;
    end
  endtask

  task automatic lockedWrites();
    check(watchdogControl, 8'h00);
    check({6'h00, wdIrq, wdResetReq}, 8'h00);
    wrCtrl(8'h72);
    check(watchdogControl, 8'h00);
    wrCtrl(8'h01);
    check(watchdogControl, 8'h01);
    @(posedge clock);
    instrEnd <= 1'b1;
    @(posedge clock);
    instrEnd <= 1'b0;
    wrCtrl(8'h72);
    check(watchdogControl, 8'h00);
  endtask

  task automatic irqResponse();
    int r0;
    r0 = rstCount;
    unlockWrite(8'h0A);
    check(watchdogControl, 8'h0A);
    waitEvt(1'b0, 1000, n);
    check(8'((n >= 505 && n <= 520) ? 1 : 0), 8'h01);
    check(watchdogControl, 8'h0E);
    check({7'h00, wdIrq}, 8'h00);
    check(8'(rstCount - r0), 8'h00);
    unlockWrite(8'h0A);
    check(watchdogControl, 8'h0A);
    r0 = irqCount;
    repeat (4)
    begin
      repeat (300) @(posedge clock);
      unlockWrite(8'h0A);
    end
    check(8'(irqCount - r0), 8'h00);
  endtask

  task automatic resetResponse();
    int i0;
    i0 = irqCount;
    unlockWrite(8'h02);
    waitEvt(1'b1, 1000, n);
    repeat (3) @(posedge clock);
    #1;
    check(watchdogControl, 8'h04);
    check(8'(irqCount - i0), 8'h00);
    unlockWrite(8'h8A);
    waitEvt(1'b1, 10, n);
    check(8'((n < 10) ? 1 : 0), 8'h01);
    doReset();
    check(watchdogControl, 8'h00);
  endtask

  task automatic supplyDrop();
    int r0;
    unlockWrite(8'h02);
    check(watchdogControl, 8'h02);
    @(posedge clock);
    supplyMonitorIrq <= 1'b1;
    @(posedge clock);
    supplyMonitorIrq <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check(watchdogControl, 8'h00);
    // Reserved prescaler 9 armed: no expiry may follow
    r0 = rstCount;
    unlockWrite(8'h92);
    repeat (600) @(posedge clock);
    #1;
    check(watchdogControl, 8'h92);
    check(8'(rstCount - r0), 8'h00);
  endtask

  initial
  begin
    doReset();
    lockedWrites();
    irqResponse();
    resetResponse();
    supplyDrop();
    print_verdict();
  end
endmodule
